/* File: common/dsj_pkg.sv */
// constants, types and register map of the decrement/skip/jump unit
// assumes an apb slave with byte addresses and 32-bit words
package dsj_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_WACC = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_LATCH_HIGH = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_FADDR = 8'h14;
  localparam logic [7:0] OFF_FDATA = 8'h18;

  ////////////////////////////////////////////////////////////////////////
  // status field positions
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int STAT_BUSY = 4;
  localparam int STAT_SKIP = 5;
  localparam int STAT_ILL = 6;

  ////////////////////////////////////////////////////////////////////////
  // opcode fields and reset values
  localparam logic [6:0] OPC_DEC = 7'h03;
  localparam logic [6:0] OPC_DSZ = 7'h0b;
  localparam logic [6:0] OPC_DSNZ = 7'h13;
  localparam logic [2:0] OPC_JUMP = 3'h6;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] INSTR_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_DEC = 3'b001,
    OP_DSZ = 3'b010,
    OP_DSNZ = 3'b011,
    OP_JUMP = 3'b100
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } state_e;

  typedef struct packed {
    op_e op;
    logic dest_f;
    logic [7:0] faddr;
    logic [12:0] lit;
  } decoded_s;

  typedef struct packed {
    logic ov;
    logic z;
    logic dc;
    logic c;
  } flags_s;

  typedef struct packed {
    logic [7:0] result;
    flags_s flags;
  } dec_result_s;

endpackage : dsj_pkg

/* File: verification/dsj_checker.sv */
// port-level assertions for the decrement/skip/jump unit
// assumes only the apb ports of the top module are visible
module dsj_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] instr_q;
  logic [4:0] age;
  logic jvalid, pc_fresh, fvalid;
  logic [2:0] pc_hi;
  logic [3:0] flags_q;
  // lane 1 alone also moves the pc, so pc writes are seen without lane 0
  wire wr_any = psel && penable && pready && pwrite;
  wire wr_take = wr_any && pstrb[0];
  wire instr_wr = wr_take && paddr == dsj_pkg::OFF_INSTR;
  wire is_jump = pwdata[15:13] == dsj_pkg::OPC_JUMP;
  wire is_dec = pwdata[15:9] == dsj_pkg::OPC_DEC;
  wire pc_wr = wr_any && paddr == dsj_pkg::OFF_PC;
  // reads while busy may show intermediate state, so wait three edges
  wire rd_acc = psel && penable && !pwrite && age >= 5'd3;
  wire acc_wr = psel && penable && pwrite;
  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= dsj_pkg::INSTR_RESET;
      age <= 5'd31;
      {jvalid, pc_fresh, fvalid, pc_hi, flags_q} <= 10'h080;
    end else begin
      if (age != 5'd31) age <= age + 5'd1;
      if (instr_wr) begin
        instr_q <= pwdata[15:0];
        age <= 5'd0;
        jvalid <= is_jump;
        pc_fresh <= pc_fresh && is_jump;
        if (is_dec) fvalid <= 1'b0;
      end
      if (pc_wr) jvalid <= 1'b0;
      if (pc_wr && pstrb[1]) {pc_fresh, pc_hi} <= {1'b1, pwdata[15:13]};
      if (wr_take && paddr == dsj_pkg::OFF_STATUS)
        {fvalid, flags_q} <= {1'b1, pwdata[3:0]};
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_jump_stall: assert property (instr_wr && is_jump |=>
    (!acc_wr || !pready) [*2]) else $error("jump not two cycles");
  a_dec_single: assert property (instr_wr && is_dec |=>
    ##1 (!acc_wr || pready)) else $error("plain decrement stalled");
  a_stall_bound: assert property (acc_wr && !pready |->
    ##[1:2] pready) else $error("stall too long");
  a_instr_back: assert property (rd_acc && paddr == dsj_pkg::OFF_INSTR
    |-> prdata[15:0] == instr_q) else $error("instr readback");
  a_jump_pc_low: assert property (rd_acc && jvalid
    && paddr == dsj_pkg::OFF_PC |-> prdata[12:0] == instr_q[12:0])
    else $error("jump target wrong");
  a_jump_page: assert property (rd_acc && jvalid && pc_fresh
    && paddr == dsj_pkg::OFF_PC |-> prdata[15:13] == pc_hi)
    else $error("jump left page");
  a_latch_copy: assert property (rd_acc && jvalid && pc_fresh
    && paddr == dsj_pkg::OFF_LATCH_HIGH
    |-> prdata[7:0] == {pc_hi, instr_q[12:8]}) else $error("latch wrong");
  a_flags_kept: assert property (rd_acc && fvalid
    && paddr == dsj_pkg::OFF_STATUS |-> prdata[3:0] == flags_q)
    else $error("flags changed");
endmodule : dsj_checker

bind decrement_skip_and_jump_exec dsj_checker u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

/* File: verification/testbench.sv */
// self-checking bench: apb master tasks and instruction sequences
// assumes the checker is bound to the unit in a separate file
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, skip;
  logic [7:0] paddr, val, f;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [6:0] opc;
  int errors, checked, nw;
  decrement_skip_and_jump_exec DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////
  // entered just after an edge; psel stays up so transfers run back to back
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    nw = 0;
    // answer is taken at the rising edge that ends the access
    @(posedge pclk);
    while (pready !== 1'b1) begin
      nw++;
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rdr
  task automatic summarize();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // plain decrement of one, back into f, then into the accumulator
    wr(dsj_pkg::OFF_FADDR, 32'h5);
    wr(dsj_pkg::OFF_FDATA, 32'h1);
    wr(dsj_pkg::OFF_INSTR, 32'({dsj_pkg::OPC_DEC, 1'b1, 8'h05}));
    // a read issued at once would capture the state before the commit
    wr(dsj_pkg::OFF_FADDR, 32'h5);
    `CHK(nw, 0)
    rdr(dsj_pkg::OFF_STATUS);
    `CHK(rd[dsj_pkg::FLAG_Z], 1'b1)
    rdr(dsj_pkg::OFF_FDATA);
    `CHK(rd[7:0], 8'h00)
    wr(dsj_pkg::OFF_FDATA, 32'h10);
    wr(dsj_pkg::OFF_INSTR, 32'({dsj_pkg::OPC_DEC, 1'b0, 8'h05}));
    wr(dsj_pkg::OFF_FADDR, 32'h5);
    `CHK(nw, 0)
    rdr(dsj_pkg::OFF_WACC);
    `CHK(rd[7:0], 8'h0f)
    rdr(dsj_pkg::OFF_FDATA);
    `CHK(rd[7:0], 8'h10)
    rdr(dsj_pkg::OFF_STATUS);
    `CHK(rd[dsj_pkg::FLAG_Z], 1'b0)
    // both skip forms, each with a zero and a non-zero result
    for (int i = 0; i < 4; i++) begin
      opc = (i < 2) ? dsj_pkg::OPC_DSZ : dsj_pkg::OPC_DSNZ;
      val = i[0] ? 8'h01 : 8'h03;
      skip = (val == 8'h01) == (i < 2);
      f = 8'h20 + 8'(i);
      wr(dsj_pkg::OFF_FADDR, 32'(f));
      wr(dsj_pkg::OFF_FDATA, 32'(val));
      wr(dsj_pkg::OFF_STATUS, 32'ha);
      wr(dsj_pkg::OFF_PC, 32'h100);
      wr(dsj_pkg::OFF_INSTR, 32'({opc, 1'b1, f}));
      wr(dsj_pkg::OFF_FADDR, 32'(f));
      `CHK(nw, skip ? 1 : 0)
      rdr(dsj_pkg::OFF_FDATA);
      `CHK(rd[7:0], val - 8'h01)
      rdr(dsj_pkg::OFF_PC);
      `CHK(rd[15:0], skip ? 16'h0102 : 16'h0101)
      rdr(dsj_pkg::OFF_STATUS);
      `CHK(rd[3:0], 4'ha)
      `CHK(rd[dsj_pkg::STAT_SKIP], skip)
    end
    // jump from a page above zero keeps the page bits
    wr(dsj_pkg::OFF_STATUS, 32'h5);
    wr(dsj_pkg::OFF_PC, 32'h6abc);
    wr(dsj_pkg::OFF_INSTR, 32'({dsj_pkg::OPC_JUMP, 13'h1234}));
    wr(dsj_pkg::OFF_FADDR, 32'h0);
    `CHK(nw, 1)
    rdr(dsj_pkg::OFF_PC);
    `CHK(rd[15:0], 16'h7234)
    rdr(dsj_pkg::OFF_LATCH_HIGH);
    `CHK(rd[7:0], 8'h72)
    rdr(dsj_pkg::OFF_INSTR);
    `CHK(rd[15:0], 16'hd234)
    rdr(dsj_pkg::OFF_STATUS);
    `CHK(rd[3:0], 4'h5)
    // an unsupported word only steps the pc and marks itself in status
    wr(dsj_pkg::OFF_INSTR, 32'h0);
    wr(dsj_pkg::OFF_FADDR, 32'h0);
    `CHK(nw, 0)
    rdr(dsj_pkg::OFF_STATUS);
    `CHK(rd[6:0], 7'h45)
    // unmapped place answers with an error and zero data
    rdr(8'h40);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    summarize();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    errors++;
    summarize();
  end
endmodule : testbench

/* File: verilog/dec_alu.sv */
// eight-bit decrement with borrow-style status flags
// assumes carry means no borrow, as in the core's subtract
module dec_alu (
  input wire logic [7:0] value,
  output dsj_pkg::dec_result_s res
);

  wire logic [7:0] result = value - 8'h01;

  assign res.result = result;
  assign res.flags.z = result == 8'h00;
  assign res.flags.c = value != 8'h00;
  assign res.flags.dc = value[3:0] != 4'h0;
  assign res.flags.ov = value == 8'h80;

endmodule : dec_alu

/* File: verilog/decrement_skip_and_jump_exec.sv */
// execution unit for decrement, decrement-skip and in-page jump
// assumes one apb master on pclk; instructions arrive via a register
// write, the register image stands in for the prefetch slot
//
// The register addresses and the APB interface to the registers were left to the implementer.

////////////////////////////////////////////////////////////////////////
// Summary of operation
// - decrement-skip forms read data register f and subtract one
// - destination bit 0 writes accumulator, 1 writes register f back
// - decrement-skip-on-zero skips next instruction when result zero
// - on non-zero result it runs next instruction, pc plus one
// - decrement-skip-on-nonzero skips when result non-zero, else runs on
// - jump is one word: top bits 110, thirteen bit literal below
// - jump loads the literal into pc bits 12 down to 0
// - jump then copies upper eight pc bits into the high latch
// - jump always takes two cycles, second is a no-operation
// - jump stays in current 8k page, pc bits above 12 unchanged
// - plain decrement sets zero flag when result becomes zero
module decrement_skip_and_jump_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] mem [0:255];
  dsj_pkg::state_e state;
  logic [15:0] ir;
  logic [15:0] pc;
  logic [7:0] pc_latch_high;
  logic [7:0] wacc;
  logic [7:0] faddr;
  dsj_pkg::flags_s flags;
  logic skip_pend;
  logic skipped;
  logic illegal;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = a == off;
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire logic busy = state != dsj_pkg::ST_IDLE;
  wire logic setup = psel & ~penable;
  wire logic access = psel & penable;
  wire logic sel_instr = hit(paddr, dsj_pkg::OFF_INSTR);
  wire logic sel_wacc = hit(paddr, dsj_pkg::OFF_WACC);
  wire logic sel_pc = hit(paddr, dsj_pkg::OFF_PC);
  wire logic sel_latch_high = hit(paddr, dsj_pkg::OFF_LATCH_HIGH);
  wire logic sel_status = hit(paddr, dsj_pkg::OFF_STATUS);
  wire logic sel_faddr = hit(paddr, dsj_pkg::OFF_FADDR);
  wire logic sel_fdata = hit(paddr, dsj_pkg::OFF_FDATA);
  wire logic mapped = sel_instr | sel_wacc | sel_pc | sel_latch_high |
                      sel_status | sel_faddr | sel_fdata;
  // writes wait out a running instruction so state never has two writers
  wire logic wr_stall = access & pwrite & busy;
  wire logic wr_ok = access & pwrite & ~busy & mapped;
  wire logic wr_lo = wr_ok & pstrb[0];
  wire logic wr_hi = wr_ok & pstrb[1];
  wire logic wr_instr = wr_lo & sel_instr;
  wire logic wr_wacc = wr_lo & sel_wacc;
  wire logic wr_pc_lo = wr_lo & sel_pc;
  wire logic wr_pc_hi = wr_hi & sel_pc;
  wire logic wr_latch_high = wr_lo & sel_latch_high;
  wire logic wr_status = wr_lo & sel_status;
  wire logic wr_faddr = wr_lo & sel_faddr;
  wire logic wr_fdata = wr_lo & sel_fdata;

  assign pready = ~wr_stall;
  assign pslverr = access & ~mapped;

  ////////////////////////////////////////////////////////////////////////
  // decode and arithmetic
  dsj_pkg::decoded_s dec;
  dsj_pkg::dec_result_s alu;

  instr_decode u_decode (
    .instr(ir),
    .dec(dec)
  );

  wire logic [7:0] operand = mem[dec.faddr];

  dec_alu u_alu (
    .value(operand),
    .res(alu)
  );

  wire logic exec = state == dsj_pkg::ST_EXEC;
  wire logic flush = state == dsj_pkg::ST_FLUSH;
  wire logic is_dec = dec.op == dsj_pkg::OP_DEC;
  wire logic is_dsz = dec.op == dsj_pkg::OP_DSZ;
  wire logic is_dsnz = dec.op == dsj_pkg::OP_DSNZ;
  wire logic is_jump = dec.op == dsj_pkg::OP_JUMP;
  wire logic is_arith = is_dec | is_dsz | is_dsnz;
  wire logic res_zero = alu.result == 8'h00;
  wire logic take_skip = (is_dsz & res_zero) |
                         (is_dsnz & ~res_zero);
  // only bits 12..0 move, so the jump cannot leave its 8k page
  wire logic [15:0] jump_pc = {pc[15:13], dec.lit};

  ////////////////////////////////////////////////////////////////////////
  // next values
  wire logic go_flush = exec & (is_jump | take_skip);
  wire logic step_pc = (exec & ~is_jump) | (flush & skip_pend);

  // code 2'b11 cannot arise; the default sends it back to idle
  dsj_pkg::state_e next_state;
  always_comb begin
    unique case (state)
      dsj_pkg::ST_IDLE: begin
        next_state = wr_instr ? dsj_pkg::ST_EXEC : dsj_pkg::ST_IDLE;
      end
      dsj_pkg::ST_EXEC: begin
        next_state = go_flush ? dsj_pkg::ST_FLUSH : dsj_pkg::ST_IDLE;
      end
      dsj_pkg::ST_FLUSH: begin
        next_state = dsj_pkg::ST_IDLE;
      end
      default: begin
        next_state = dsj_pkg::ST_IDLE;
      end
    endcase
  end

  wire logic [15:0] pc_sw = {wr_pc_hi ? pwdata[15:8] : pc[15:8],
                             wr_pc_lo ? pwdata[7:0] : pc[7:0]};
  wire logic [15:0] next_pc = (exec & is_jump) ? jump_pc :
                              step_pc ? pc + 16'h0001 :
                              pc_sw;
  wire logic [7:0] next_pc_latch_high =
    (exec & is_jump) ? jump_pc[15:8] :
    wr_latch_high ? pwdata[7:0] : pc_latch_high;
  wire logic acc_wr = exec & is_arith & ~dec.dest_f;
  wire logic [7:0] next_wacc = acc_wr ? alu.result :
                               wr_wacc ? pwdata[7:0] : wacc;
  // only the plain decrement touches flags; skip forms and jump keep them
  dsj_pkg::flags_s next_flags;
  assign next_flags = (exec & is_dec) ? alu.flags :
                      wr_status ? dsj_pkg::flags_s'(pwdata[3:0]) : flags;

  wire logic mem_exec_we = exec & is_arith & dec.dest_f;
  wire logic mem_we = mem_exec_we | wr_fdata;
  wire logic [7:0] mem_wa = mem_exec_we ? dec.faddr : faddr;
  wire logic [7:0] mem_wd = mem_exec_we ? alu.result : pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dsj_pkg::ST_IDLE;
      ir <= dsj_pkg::INSTR_RESET;
      skip_pend <= 1'b0;
    end else begin
      state <= next_state;
      ir <= wr_instr ? pwdata[15:0] : ir;
      skip_pend <= exec & take_skip;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= dsj_pkg::PC_RESET;
      pc_latch_high <= dsj_pkg::BYTE_RESET;
    end else begin
      pc <= next_pc;
      pc_latch_high <= next_pc_latch_high;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wacc <= dsj_pkg::BYTE_RESET;
      flags <= '0;
      faddr <= dsj_pkg::BYTE_RESET;
    end else begin
      wacc <= next_wacc;
      flags <= next_flags;
      faddr <= wr_faddr ? pwdata[7:0] : faddr;
    end
  end

  // sticky outcome bits, cleared when the next instruction is issued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skipped <= 1'b0;
      illegal <= 1'b0;
    end else if (exec) begin
      skipped <= take_skip;
      illegal <= dec.op == dsj_pkg::OP_NONE;
    end else if (wr_instr) begin
      skipped <= 1'b0;
      illegal <= 1'b0;
    end
  end

  // data memory has no reset; software must initialise what it uses
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path, captured in the setup cycle
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[dsj_pkg::FLAG_OV:dsj_pkg::FLAG_C] = flags;
    status_word[dsj_pkg::STAT_BUSY] = busy;
    status_word[dsj_pkg::STAT_SKIP] = skipped;
    status_word[dsj_pkg::STAT_ILL] = illegal;
  end

  wire logic [31:0] read_value =
    sel_instr ? {16'h0000, ir} :
    sel_wacc ? {24'h000000, wacc} :
    sel_pc ? {16'h0000, pc} :
    sel_latch_high ? {24'h000000, pc_latch_high} :
    sel_status ? status_word :
    sel_faddr ? {24'h000000, faddr} :
    sel_fdata ? {24'h000000, mem[faddr]} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      prdata <= read_value;
    end
  end

endmodule : decrement_skip_and_jump_exec

/* File: verilog/instr_decode.sv */
// instruction word decoder for decrement, skip and jump forms
// assumes a stable 16-bit instruction word from the same clock domain
module instr_decode (
  input wire logic [15:0] instr,
  output dsj_pkg::decoded_s dec
);

  wire logic is_dec = instr[15:9] == dsj_pkg::OPC_DEC;
  wire logic is_dsz = instr[15:9] == dsj_pkg::OPC_DSZ;
  wire logic is_dsnz = instr[15:9] == dsj_pkg::OPC_DSNZ;
  wire logic is_jump = instr[15:13] == dsj_pkg::OPC_JUMP;

  assign dec.op = is_jump ? dsj_pkg::OP_JUMP :
                  is_dsz ? dsj_pkg::OP_DSZ :
                  is_dsnz ? dsj_pkg::OP_DSNZ :
                  is_dec ? dsj_pkg::OP_DEC : dsj_pkg::OP_NONE;
  assign dec.dest_f = instr[8];
  assign dec.faddr = instr[7:0];
  assign dec.lit = instr[12:0];

endmodule : instr_decode
